// ==== bench/tb_top.sv ====
// tb_top: register-level tests of the serial receiver over wishbone.
// assumes urf_tx_model drives the serial line of the receiver.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [3:0] CT = urf_pkg::OFS_CTRL;
  localparam logic [3:0] ST = urf_pkg::OFS_STATUS;
  localparam logic [3:0] DT = urf_pkg::OFS_DATA;
  localparam logic [3:0] CN = urf_pkg::OFS_COUNT;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic baudTick16 = 1'b0;
  logic txEmpty = 1'b0;
  logic txIdle = 1'b0;
  logic uartClkOff = 1'b0;
  logic [3:0] wbAdr = 4'h0;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic [31:0] rdv;
  logic wbAck;
  logic rxPin;
  logic rxPinOwn;
  logic uartIrq_b;
  logic [1:0] fs [3] = '{2'b10, 2'b01, 2'b11};
  int n_errors = 0;
  int num_checks = 0;
  int irqCnt = 0;
  int cyc = 0;
  int i0 = 0;

  initial forever #25 clock = ~clock;

  urf_tx_model u_tx (.clock(clock), .baudTick16(baudTick16), .rxLine(rxPin));

  urf_receiver #(.FIFO_DEPTH(4)) DUT (.clock(clock), .rst_b(rst_b), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .baudTick16(baudTick16), .rxPin(rxPin),
    .txEmpty(txEmpty), .txIdle(txIdle), .uartClkOff(uartClkOff),
    .rxPinOwn(rxPinOwn), .uartIrq_b(uartIrq_b));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // tick every other clock keeps a bit at 32 cycles
  always @(posedge clock)
  begin
    baudTick16 <= ~baudTick16;
    cyc <= cyc + 1;
    if (uartIrq_b === 1'b0)
      irqCnt <= irqCnt + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // hold the request until ack is sampled high at a rising edge
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    do @(posedge clock); while (wbAck !== 1'b1);
    rdv = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdv & m, e);
  endtask : rdc

  task automatic irqd(input int e);
    chk(32'(irqCnt - i0), 32'(e));
    i0 = irqCnt;
  endtask : irqd

  task automatic snd(input logic [8:0] w, input int n, input logic nz);
    u_tx.send(w, n, 2'b11, 1, nz);
  endtask : snd

  initial
  begin
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    chk({31'h0, rxPinOwn}, 32'h0);
    chk({31'h0, uartIrq_b}, 32'h1);
    wr(ST, 32'hFFFFFFFF);
    rdc(ST, 32'h1F, 32'h0);
    rdc(CN, 32'hFF, 32'h0);
    rdc(DT, 32'h1FF, 32'h0);
    $display("test reset done");
    wr(CT, 32'h21);
    i0 = irqCnt;
    chk({31'h0, rxPinOwn}, 32'h1);
    fork
      snd(9'h0A5, 8, 1'b0);
      begin
        repeat (100) @(posedge clock);
        rdc(ST, 32'h21, 32'h0);
      end
    join
    irqd(1);
    rdc(CN, 32'hFF, 32'h1);
    rdc(ST, 32'h21, 32'h21);
    rdc(DT, 32'h1FF, 32'h0A5);
    rdc(ST, 32'h1, 32'h0);
    wr(CT, 32'h3);
    snd(9'h1C3, 9, 1'b0);
    rdc(ST, 32'h40, 32'h40);
    rdc(DT, 32'h1FF, 32'h1C3);
    $display("test frame done");
    wr(CT, 32'h1821);
    i0 = irqCnt;
    for (int i = 0; i < 5; i++)
      snd(9'(17 + i), 8, 1'b0);
    irqd(2);
    rdc(CN, 32'hFF, 32'h4);
    rdc(ST, 32'h3, 32'h3);
    for (int i = 0; i < 4; i++)
      rdc(DT, 32'h1FF, 32'(17 + i));
    rdc(ST, 32'h3, 32'h0);
    $display("test overrun done");
    // a single set bit: wrong for even and mark, right for odd and space
    for (int t = 0; t < 4; t++)
    begin
      wr(CT, 32'h5 | (32'(t) << 3));
      snd(9'h001, 8, 1'b0);
      rdc(ST, 32'h10, (t % 2 == 0) ? 32'h10 : 32'h0);
      rdc(DT, 32'h1FF, 32'h1);
    end
    for (int f = 0; f < 3; f++)
    begin
      wr(CT, (f == 0) ? 32'h1 : 32'h101);
      u_tx.send(9'h05A, 8, fs[f], (f == 0) ? 1 : 2, 1'b0);
      rdc(ST, 32'h8, (f < 2) ? 32'h8 : 32'h0);
      rdc(DT, 32'h1FF, 32'h5A);
    end
    irqd(0);
    $display("test errors done");
    wr(CT, 32'h1);
    fork
      u_tx.lowFor(14);
      begin
        repeat (400) @(posedge clock);
        rdc(ST, 32'h229, 32'h229);
      end
    join
    // a low line wrongly taken as a start would have pushed a second word by now
    repeat (400) @(posedge clock);
    rdc(CN, 32'hFF, 32'h1);
    rdc(DT, 32'h1FF, 32'h0);
    wr(CT, 32'h21);
    i0 = irqCnt;
    snd(9'h0A5, 8, 1'b1);
    irqd(1);
    rdc(ST, 32'h5, 32'h5);
    rdc(DT, 32'h1FF, 32'h0A5);
    rdc(ST, 32'h4, 32'h0);
    $display("test break noise done");
    // trigger level two: the first word can only interrupt through address detect
    wr(CT, 32'h861);
    i0 = irqCnt;
    snd(9'h080, 8, 1'b0);
    irqd(1);
    snd(9'h07F, 8, 1'b0);
    irqd(0);
    rdc(DT, 32'h1FF, 32'h80);
    rdc(DT, 32'h1FF, 32'h7F);
    wr(CT, 32'h200);
    i0 = irqCnt;
    txEmpty <= 1'b1;
    repeat (4) @(posedge clock);
    txIdle <= 1'b1;
    repeat (4) @(posedge clock);
    irqd(1);
    txIdle <= 1'b0;
    wr(CT, 32'h400);
    txIdle <= 1'b1;
    repeat (4) @(posedge clock);
    irqd(1);
    $display("test sources done");
    wr(CT, 32'h18A1);
    uartClkOff <= 1'b1;
    i0 = irqCnt;
    fork
      u_tx.lowFor(1);
      begin
        repeat (8) @(posedge clock);
        irqd(1);
      end
    join
    $display("test wake done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// ==== bench/urf_tx_model.sv ====
// urf_tx_model: far-end serial transmitter driving the receive line.
// assumes baudTick16 pulses at 16x the baud rate; line idles high.
`timescale 1ns/1ns
`default_nettype none
module urf_tx_model (
  input wire logic clock,
  input wire logic baudTick16,
  output logic rxLine
);
  initial rxLine = 1'b1;

  // nz inverts one tick mid-bit: a lone bad sample the majority must absorb
  task automatic bitOut(input logic v, input logic nz);
    for (int t = 0; t < 16; t++)
    begin
      do @(posedge clock); while (baudTick16 !== 1'b1);
      rxLine <= (nz && t == 8) ? ~v : v;
    end
  endtask : bitOut

  // st[0] first stop level, st[1] second; ends with one idle bit time
  task automatic send(input logic [8:0] w, input int n, input logic [1:0] st,
    input int ns, input logic nz);
    bitOut(1'b0, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      bitOut(w[i], nz && i == 2);
    end
    bitOut(st[0], 1'b0);
    if (ns == 2)
    begin
      bitOut(st[1], 1'b0);
    end
    bitOut(1'b1, 1'b0);
  endtask : send

  task automatic lowFor(input int nb);
    for (int b = 0; b < nb; b++)
    begin
      bitOut(1'b0, 1'b0);
    end
    bitOut(1'b1, 1'b0);
    bitOut(1'b1, 1'b0);
  endtask : lowFor
endmodule : urf_tx_model
`default_nettype wire

// ==== src/urf_pkg.sv ====
// urf_pkg: constants, register map, field layout and types of the
// serial receiver with receive FIFO and error flags.
// assumes a 32-bit classic wishbone register bus and a 16x baud tick.
package urf_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA = 4'h8;
  localparam logic [3:0] OFS_COUNT = 4'hC;
  // serial_ctrl_one / serial_ctrl_two fields, one merged control word
  localparam int CTL_RX_EN = 0;
  localparam int CTL_WLS = 1;
  localparam int CTL_PAR_EN = 2;
  localparam int CTL_PAR_TYPE = 3;
  localparam int CTL_RIE = 5;
  localparam int CTL_ADDR_EN = 6;
  localparam int CTL_WAKE = 7;
  localparam int CTL_STOP2 = 8;
  localparam int CTL_TEIE = 9;
  localparam int CTL_TIIE = 10;
  localparam int CTL_TRIG = 11;
  localparam int CTL_WIDTH = 13;
  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 13'h0000;
  // serial_status_reg fields
  localparam int ST_AVAIL = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_NOISE = 2;
  localparam int ST_FRAMING = 3;
  localparam int ST_PARITY = 4;
  localparam int ST_IDLE = 5;
  localparam int ST_NINTH = 6;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_IDLE = 8;
  localparam int ST_BRK_IDLE = 9;
  // parity types
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  // oversampling: 16 ticks per bit, majority taken on ticks 7, 8, 9
  localparam logic [3:0] TICK_FIRST_SAMPLE = 4'h7;
  localparam logic [3:0] TICK_LAST_SAMPLE = 4'h9;
  localparam logic [3:0] TICK_BIT_END = 4'hF;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;
  localparam int FIFO_DEPTH_DEF = 4;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b011,
    RX_STOP = 3'b010,
    RX_STOP2 = 3'b110,
    RX_BRK_WAIT = 3'b111
  } urf_state_e;

  typedef struct packed {
    logic parityErr;
    logic framingErr;
    logic [8:0] word;
  } urf_entry_s;
endpackage : urf_pkg

// ==== src/urf_receiver.sv ====
// urf_receiver: receive half of an asynchronous serial port with a
// four word receive FIFO, error flags and the merged interrupt pulse.
// assumes baudTick16 pulses one cycle at 16x the baud rate, rxPin and
// the transmitter flags are synchronous to clock.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

// Function
// - accept 8 or 9 data bits; ninth bit kept as status
// - recovery runs on the 16x tick, shifting once per bit time
// - each bit level is the majority of three samples
// - after the stop bit the word enters the FIFO if room
// - FIFO holds four words while a fifth is assembled
// - word finishing on a full FIFO is dropped, overrun set, interrupt
// - receiver enable takes the pin and starts the start bit search
// - data available flag while FIFO not empty; count is readable
// - receive interrupt when fill reaches trigger level after a transfer
// - long break ends as frame, sets framing, available, idle, zero word
// - after a break wait for high level before a new start bit
// - idle flag low from start detect until the stop bit is read
// - noise sets noise flag with the word, cleared by status-data reads
// - low stop bit sets framing error, both checked with two stops
// - wrong parity for the selected type sets parity error
// - all sources merge into one low interrupt pulse
// - two transmit sources own enables, receive sources share one except address detect, gated only by its own
// - address detect raises the interrupt without a status flag
// - falling pin edge while clock stopped raises wake interrupt
// - flags read-only, cleared only by the access sequences
// - with address detect, receive interrupt only when top bit high
module urf_receiver #(
  parameter int FIFO_DEPTH = urf_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic baudTick16,
  input wire logic rxPin,
  input wire logic txEmpty,
  input wire logic txIdle,
  input wire logic uartClkOff,
  output logic rxPinOwn,
  output logic uartIrq_b
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // pointers wrap naturally, and the trigger field reaches four
  generate
    if (FIFO_DEPTH < 4 || (1 << PW) != FIFO_DEPTH)
    begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two of at least 4");
    end
  endgenerate

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : majority

  function automatic logic isAccess(input logic [3:0] a, input logic [3:0] ofs);
    isAccess = (a[3:2] == ofs[3:2]);
  endfunction : isAccess

  urf_pkg::urf_state_e state_q, state_d;
  logic [urf_pkg::CTL_WIDTH-1:0] ctrl_q, ctrl_d;
  logic [3:0] tick_q, bitIdx_q;
  logic [2:0] samp_q;
  logic [8:0] shift_q;
  logic frameNoise_q, frameFerr_q;
  logic rxPrev_q;
  urf_pkg::urf_entry_s fifoMem_q [FIFO_DEPTH];
  logic [PW-1:0] wrPtr_q, rdPtr_q;
  logic [CW-1:0] count_q;
  logic overrun_q, noise_q, armed_q;
  logic txEmptyPrev_q, txIdlePrev_q;
  logic ack_q;
  logic [31:0] datR_q;
  logic irq_bq;

  // control fields
  wire logic receiver_enable = ctrl_q[urf_pkg::CTL_RX_EN];
  wire logic wls = ctrl_q[urf_pkg::CTL_WLS];
  wire logic parEn = ctrl_q[urf_pkg::CTL_PAR_EN];
  wire logic [1:0] parType = ctrl_q[urf_pkg::CTL_PAR_TYPE +: 2];
  wire logic rcv_irq_enable = ctrl_q[urf_pkg::CTL_RIE];
  wire logic addrEn = ctrl_q[urf_pkg::CTL_ADDR_EN];
  wire logic wakeEn = ctrl_q[urf_pkg::CTL_WAKE];
  wire logic stop2 = ctrl_q[urf_pkg::CTL_STOP2];
  wire logic teie = ctrl_q[urf_pkg::CTL_TEIE];
  wire logic tiie = ctrl_q[urf_pkg::CTL_TIIE];
  wire logic [CW-1:0] trigLevel = CW'(ctrl_q[urf_pkg::CTL_TRIG +: 2]) + CW'(1);

  // bus decode: side effects happen once, on the cycle before ack
  wire logic busReq = wbCyc & wbStb & ~ack_q;
  wire logic wrCtrl = busReq & wbWe & isAccess(wbAdr, urf_pkg::OFS_CTRL);
  wire logic rdStatus = busReq & ~wbWe & isAccess(wbAdr, urf_pkg::OFS_STATUS);
  wire logic rdData = busReq & ~wbWe & isAccess(wbAdr, urf_pkg::OFS_DATA);

  // bit timing
  wire logic bitEnd = baudTick16 & (tick_q == urf_pkg::TICK_BIT_END);
  wire logic inWindow = (tick_q >= urf_pkg::TICK_FIRST_SAMPLE)
      && (tick_q <= urf_pkg::TICK_LAST_SAMPLE);
  wire logic bitLevel = majority(samp_q);
  wire logic bitNoisy = (samp_q != 3'h0) && (samp_q != 3'h7);
  wire logic [3:0] frameBits = wls ? urf_pkg::BITS_LONG : urf_pkg::BITS_SHORT;
  wire logic lastData = (bitIdx_q == frameBits - 4'h1);
  wire logic startDet = (state_q == urf_pkg::RX_IDLE) & receiver_enable & ~rxPin;
  wire logic stopSeen = bitEnd & ((state_q == urf_pkg::RX_STOP2)
      | ((state_q == urf_pkg::RX_STOP) & ~stop2));
  wire logic frameFerr = frameFerr_q | ~bitLevel;

  // assembled word; an 8-bit frame sits one place high in the shifter
  wire logic [8:0] word = wls ? shift_q : {1'b0, shift_q[8:1]};
  wire logic addrBit = wls ? word[8] : word[7];
  wire logic [8:0] parSpan = parEn ? word : 9'h000;
  wire logic parBit = wls ? word[8] : word[7];
  wire logic parityBad = parEn & ((parType == urf_pkg::PAR_EVEN && ^parSpan)
      | (parType == urf_pkg::PAR_ODD && !(^parSpan))
      | (parType == urf_pkg::PAR_MARK && !parBit)
      | (parType == urf_pkg::PAR_SPACE && parBit));

  // FIFO
  wire logic fifoFull = (count_q == CW'(FIFO_DEPTH));
  wire logic fifoEmpty = (count_q == '0);
  wire logic pushReq = stopSeen;
  wire logic push = pushReq & ~fifoFull;
  wire logic setOverrun = pushReq & fifoFull;
  wire logic pop = rdData & ~fifoEmpty;
  wire logic seqClear = rdData & armed_q;
  wire logic [CW-1:0] countNext = CW'(count_q + CW'(push) - CW'(pop));
  urf_pkg::urf_entry_s head, newEntry;
  assign head = fifoMem_q[rdPtr_q];
  assign newEntry = '{parityErr: parityBad, framingErr: frameFerr, word: word};

  // interrupt sources
  wire logic rxTrigger = push & rcv_irq_enable & (countNext >= trigLevel)
      & (~addrEn | addrBit);
  wire logic ovrIrq = setOverrun & rcv_irq_enable;
  wire logic addrIrq = push & addrEn & addrBit;
  wire logic txEmptyIrq = teie & txEmpty & ~txEmptyPrev_q;
  wire logic txIdleIrq = tiie & txIdle & ~txIdlePrev_q;
  wire logic wakeIrq = uartClkOff & wakeEn & rcv_irq_enable & receiver_enable & rxPrev_q & ~rxPin;
  wire logic irqAny = rxTrigger | ovrIrq | addrIrq | txEmptyIrq | txIdleIrq | wakeIrq;

  // status word
  wire logic rcvIdle = (state_q == urf_pkg::RX_IDLE) | (state_q == urf_pkg::RX_BRK_WAIT);
  logic [31:0] statusWord, readMux;
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[urf_pkg::ST_AVAIL] = ~fifoEmpty;
    statusWord[urf_pkg::ST_OVERRUN] = overrun_q;
    statusWord[urf_pkg::ST_NOISE] = noise_q;
    statusWord[urf_pkg::ST_FRAMING] = ~fifoEmpty & head.framingErr;
    statusWord[urf_pkg::ST_PARITY] = ~fifoEmpty & head.parityErr;
    statusWord[urf_pkg::ST_IDLE] = rcvIdle;
    statusWord[urf_pkg::ST_NINTH] = ~fifoEmpty & head.word[8];
    statusWord[urf_pkg::ST_TX_EMPTY] = txEmpty;
    statusWord[urf_pkg::ST_TX_IDLE] = txIdle;
    statusWord[urf_pkg::ST_BRK_IDLE] = (state_q == urf_pkg::RX_BRK_WAIT);
  end

  always_comb
  begin
    readMux = 32'h0000_0000;
    if (isAccess(wbAdr, urf_pkg::OFS_CTRL))
      readMux = 32'(ctrl_q);
    else if (isAccess(wbAdr, urf_pkg::OFS_STATUS))
      readMux = statusWord;
    else if (isAccess(wbAdr, urf_pkg::OFS_DATA))
      readMux = fifoEmpty ? 32'h0000_0000 : 32'(head.word);
    else if (isAccess(wbAdr, urf_pkg::OFS_COUNT))
      readMux = 32'(count_q);
  end

  always_comb
  begin
    ctrl_d = ctrl_q;
    if (wrCtrl && wbSel[0])
      ctrl_d[7:0] = wbDatW[7:0];
    if (wrCtrl && wbSel[1])
      ctrl_d[urf_pkg::CTL_WIDTH-1:8] = wbDatW[urf_pkg::CTL_WIDTH-1:8];
  end

  // receive sequencer
  always_comb
  begin
    state_d = state_q;
    if (!receiver_enable)
      state_d = urf_pkg::RX_IDLE;
    else
      unique case (state_q)
        urf_pkg::RX_IDLE:
          if (!rxPin)
            state_d = urf_pkg::RX_START;
        urf_pkg::RX_START:
          if (bitEnd)
            state_d = bitLevel ? urf_pkg::RX_IDLE : urf_pkg::RX_DATA;
        urf_pkg::RX_DATA:
          if (bitEnd && lastData)
            state_d = urf_pkg::RX_STOP;
        urf_pkg::RX_STOP:
          if (bitEnd)
          begin
            if (stop2)
              state_d = urf_pkg::RX_STOP2;
            else
              state_d = frameFerr ? urf_pkg::RX_BRK_WAIT : urf_pkg::RX_IDLE;
          end
        urf_pkg::RX_STOP2:
          if (bitEnd)
            state_d = frameFerr ? urf_pkg::RX_BRK_WAIT : urf_pkg::RX_IDLE;
        urf_pkg::RX_BRK_WAIT:
          if (rxPin)
            state_d = urf_pkg::RX_IDLE;
        default:
          state_d = urf_pkg::RX_IDLE;
      endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q <= urf_pkg::RX_IDLE;
      ctrl_q <= urf_pkg::CTL_RESET;
      rxPrev_q <= 1'b1;
      txEmptyPrev_q <= 1'b0;
      txIdlePrev_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      rxPrev_q <= rxPin;
      txEmptyPrev_q <= txEmpty;
      txIdlePrev_q <= txIdle;
    end
  end

  // 16x recovery counter and majority samples
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_q <= 4'h0;
      samp_q <= 3'h7;
    end
    else if (state_q == urf_pkg::RX_IDLE || state_q == urf_pkg::RX_BRK_WAIT)
    begin
      tick_q <= 4'h0;
      samp_q <= 3'h7;
    end
    else if (baudTick16)
    begin
      tick_q <= tick_q + 4'h1;
      if (inWindow)
        samp_q <= {samp_q[1:0], rxPin};
    end
  end

  // shifter runs once per bit time, lsb arrives first
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= 9'h000;
      bitIdx_q <= 4'h0;
      frameNoise_q <= 1'b0;
      frameFerr_q <= 1'b0;
    end
    else if (startDet)
    begin
      bitIdx_q <= 4'h0;
      frameNoise_q <= 1'b0;
      frameFerr_q <= 1'b0;
    end
    else if (bitEnd)
    begin
      frameNoise_q <= frameNoise_q | bitNoisy;
      if (state_q == urf_pkg::RX_DATA)
      begin
        shift_q <= {bitLevel, shift_q[8:1]};
        bitIdx_q <= bitIdx_q + 4'h1;
      end
      if (state_q == urf_pkg::RX_STOP)
        frameFerr_q <= ~bitLevel;
    end
  end

  // FIFO storage keeps no reset; only the pointers and count matter
  always_ff @(posedge clock)
  begin
    if (push)
      fifoMem_q[wrPtr_q] <= newEntry;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wrPtr_q <= wrPtr_q + PW'(push);
      rdPtr_q <= rdPtr_q + PW'(pop);
      count_q <= countNext;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overrun_q <= 1'b0;
      noise_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      overrun_q <= setOverrun | (overrun_q & ~seqClear);
      noise_q <= (push & (frameNoise_q | bitNoisy)) | (noise_q & ~seqClear);
      armed_q <= rdStatus | (armed_q & ~rdData);
    end
  end

  // wishbone answer one cycle after the request; the interrupt pulse
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      datR_q <= 32'h0000_0000;
      irq_bq <= 1'b1;
    end
    else
    begin
      ack_q <= busReq;
      datR_q <= busReq && !wbWe ? readMux : 32'h0000_0000;
      irq_bq <= ~irqAny;
    end
  end

  assign wbAck = ack_q;
  assign wbDatR = datR_q;
  assign uartIrq_b = irq_bq;
  assign rxPinOwn = ctrl_q[urf_pkg::CTL_RX_EN];

  // checks
  sequence overrunEvent;
    setOverrun && !pop;
  endsequence
  sequence breakEnd;
    pushReq && !fifoFull && word == 9'h000 && frameFerr && !rxPin;
  endsequence

  fifo_bound_a: assert property (@(posedge clock) disable iff (!rst_b)
    count_q <= CW'(FIFO_DEPTH))
    else $error("fifo count above depth");
  ovr_keep_a: assert property (@(posedge clock) disable iff (!rst_b)
    overrunEvent |=> overrun_q && count_q == $past(count_q) && wrPtr_q == $past(wrPtr_q))
    else $error("overrun did not flag or altered fifo");
  ovr_irq_a: assert property (@(posedge clock) disable iff (!rst_b)
    setOverrun && rcv_irq_enable |=> !uartIrq_b)
    else $error("overrun interrupt missing");
  avail_cnt_a: assert property (@(posedge clock) disable iff (!rst_b)
    push && !pop |=> count_q == $past(count_q) + CW'(1) && statusWord[urf_pkg::ST_AVAIL])
    else $error("push not counted");
  break_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    breakEnd |=> state_q == urf_pkg::RX_BRK_WAIT && statusWord[urf_pkg::ST_IDLE])
    else $error("break did not end in wait state");
  brk_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    state_q == urf_pkg::RX_BRK_WAIT && !rxPin && receiver_enable |=> state_q == urf_pkg::RX_BRK_WAIT)
    else $error("low line taken as start after break");
  idle_low_a: assert property (@(posedge clock) disable iff (!rst_b)
    startDet |=> (!statusWord[urf_pkg::ST_IDLE]) [*2])
    else $error("idle flag high after start");
  rx_disable_a: assert property (@(posedge clock) disable iff (!rst_b)
    !receiver_enable |=> state_q == urf_pkg::RX_IDLE)
    else $error("receiver active while disabled");
  addr_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    addrEn && push && !addrBit && !ovrIrq && !txEmptyIrq && !txIdleIrq && !wakeIrq
    |=> uartIrq_b)
    else $error("receive interrupt without address bit");
  noise_flag_a: assert property (@(posedge clock) disable iff (!rst_b)
    push && frameNoise_q |=> noise_q && count_q != '0)
    else $error("noise not flagged with data");
  wb_ack_a: assert property (@(posedge clock) disable iff (!rst_b)
    busReq |=> wbAck ##1 !wbAck)
    else $error("wishbone ack not one cycle");
endmodule : urf_receiver

`default_nettype wire
